// ---- core/tacim_pkg.sv ----
// tacim_pkg: register map, field positions and codes for the timer A
// control and interrupt mask block.
// assumes a 12-bit byte address and a 32-bit register data path.
package tacim_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IRQ_W = 11;
    localparam int CTL_W = 7;

    typedef logic [ADDR_W-1:0] tacim_addr_t;
    typedef logic [DATA_W-1:0] tacim_data_t;

    // byte offsets
    localparam tacim_addr_t OFS_CTRL = 12'h00C;
    localparam tacim_addr_t OFS_MASK = 12'h018;
    localparam tacim_addr_t OFS_RAW = 12'h01C;
    localparam tacim_addr_t OFS_MIS = 12'h020;
    localparam tacim_addr_t OFS_CLR = 12'h024;

    // control fields
    localparam int CTL_EN = 0;
    localparam int CTL_STALL = 1;
    localparam int CTL_EVT_LO = 2;
    localparam int CTL_EVT_HI = 3;
    localparam int CTL_RTC = 4;
    localparam int CTL_TRIG = 5;
    localparam int CTL_INV = 6;

    // interrupt source positions, shared by mask, raw and masked views
    localparam int IRQ_TA_TO = 0;
    localparam int IRQ_CA_MATCH = 1;
    localparam int IRQ_CA_EVT = 2;
    localparam int IRQ_RTC = 3;
    localparam int IRQ_TB_TO = 8;
    localparam int IRQ_CB_MATCH = 9;
    localparam int IRQ_CB_EVT = 10;

    localparam logic [CTL_W-1:0] CTL_RESET = 7'h00;
    localparam logic [IRQ_W-1:0] IRQ_WMASK = 11'h70F;
    localparam logic [IRQ_W-1:0] MASK_RESET = 11'h000;
    localparam logic [IRQ_W-1:0] IRQ_NONE = 11'h000;
    localparam tacim_data_t DATA_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        EDGE_RISE = 2'h0,
        EDGE_FALL = 2'h1,
        EDGE_RSVD = 2'h2,
        EDGE_BOTH = 2'h3
    } tacim_edge_e;
endpackage : tacim_pkg

// ---- core/tacim_cap_if.sv ----
// tacim_cap_if: edge selection and capture event between the control
// block and the capture edge detector.
// assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface tacim_cap_if;
    import tacim_pkg::*;
    tacim_edge_e edge_sel;
    logic arm;
    logic event_p;
    modport ctl (output edge_sel, output arm, input event_p);
    modport det (input edge_sel, input arm, output event_p);
endinterface : tacim_cap_if

// ---- core/tacim_edge.sv ----
// tacim_edge: capture pin synchroniser and selectable edge detector.
// assumes the pin is asynchronous to clock; event is one-cycle pulse.
`timescale 1ns/1ps
module tacim_edge (
    input wire logic clock, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic cap_pin, // capture pin, asynchronous
    tacim_cap_if.det cap // edge select in, event out
);
    import tacim_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic evt;
    } tacim_edge_s;

    tacim_edge_s st_q;
    tacim_edge_s st_d;
    logic rise;
    logic fall;
    logic hit;

    always_comb begin
        st_d = st_q;
        st_d.sync1 = cap_pin;
        st_d.sync2 = st_q.sync1;
        st_d.prev = st_q.sync2;
        rise = st_q.sync2 & ~st_q.prev;
        fall = ~st_q.sync2 & st_q.prev;
        // [RULE4] edge code decode
        case (cap.edge_sel)
            EDGE_RISE: hit = rise;
            EDGE_FALL: hit = fall;
            EDGE_BOTH: hit = rise | fall;
            // reserved code: no capture rather than a guess
            default: hit = 1'b0;
        endcase
        st_d.evt = cap.arm & hit;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign cap.event_p = st_q.evt;

    a_rise_only: assert property (@(posedge clock) disable iff (!reset_n) // [RULE4]
        (cap.arm && cap.edge_sel == EDGE_RISE && fall) |=> !cap.event_p)
        else $error("falling edge captured in rising mode");
    a_rsvd_quiet: assert property (@(posedge clock) disable iff (!reset_n) // [RULE4]
        (cap.edge_sel == EDGE_RSVD) |=> !cap.event_p)
        else $error("capture on reserved edge code");
    a_both_edges: assert property (@(posedge clock) disable iff (!reset_n) // [RULE4]
        (cap.arm && cap.edge_sel == EDGE_BOTH && (rise || fall))
        |=> cap.event_p)
        else $error("edge missed in both-edge mode");
endmodule : tacim_edge

// ---- core/tacim_top.sv ----
// tacim_top: timer A control fields and interrupt mask for both timers,
// with raw flags, masked view and the interrupt line.
// assumes event inputs are one-cycle pulses on clock; capture pin async.
// Functional notes
// [RULE1] output invert bit set inverts the PWM output, clear passes it.
// [RULE2] output trigger reaches other peripherals only while trigger enable set.
// [RULE3] RTC counting advances only while the RTC enable bit is set.
// [RULE4] edge field: 00 rising, 01 falling, 11 both, 10 reserved.
// [RULE5] stall bit set stops timer A while the debugger halts the processor; code stalls only timer_a_run, capture stays armed.
// [RULE6] enable bit starts timer A or its capture logic; clear disables.
// [RULE7] mask bit 1 enables its interrupt, 0 disables; RTC mask at bit 3.
// [RULE8] timer B enables: capture event bit 10, match bit 9, timeout bit 8.
// [RULE9] mask bit 2 gates the capture A event interrupt.
// [RULE10] mask bit 1 gates the capture A match interrupt.
// [RULE11] mask bit 0 gates timer A timeout; all mask bits reset to 0.
// [RULE12] raw flags set regardless of mask; write 1 to clear register clears.
// [RULE13] interrupt output high while any raw flag and its mask bit are set.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module tacim_top (
    input wire logic clock, // system clock, 40 MHz
    input wire logic reset_n, // async reset, active low
    input wire tacim_pkg::tacim_addr_t addr, // register byte address
    input wire tacim_pkg::tacim_data_t wdata, // register write data
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    output tacim_pkg::tacim_data_t rdata, // read data, cycle after strobe
    input wire logic pwm_raw, // timer A PWM from counter
    output logic pwm_out, // timer A PWM to pin
    input wire logic trig_raw, // timer A trigger from counter
    output logic trig_out, // trigger toward other peripherals
    input wire logic rtc_tick, // RTC count tick, one cycle
    output logic rtc_advance, // RTC counter advance, one cycle
    input wire logic debug_halt, // processor halted by debugger
    output logic timer_a_run, // timer A counter may run; the capture arm ignores the debug stall
    input wire logic cap_pin, // timer A capture pin, async
    input wire logic ta_timeout, // timer A timeout event
    input wire logic ca_match, // capture A match event
    input wire logic rtc_match, // RTC match event
    input wire logic tb_timeout, // timer B timeout event
    input wire logic cb_match, // capture B match event
    input wire logic cb_event, // capture B edge event
    output logic irq // interrupt, level, active high
);
    import tacim_pkg::*;

    typedef struct packed {
        logic [CTL_W-1:0] ctrl;
        logic [IRQ_W-1:0] mask;
        logic [IRQ_W-1:0] raw;
        tacim_data_t rdata;
        logic pwm;
        logic trig;
        logic rtc_adv;
        logic run;
    } tacim_top_s;

    tacim_top_s st_q;
    tacim_top_s st_d;
    logic [IRQ_W-1:0] events;
    logic [IRQ_W-1:0] clr;
    logic [IRQ_W-1:0] masked;
    logic wr_ctrl;
    logic wr_mask;
    logic wr_clr;
    logic rd_raw;

    tacim_cap_if cap ();

    tacim_edge u_edge (
        .clock(clock),
        .reset_n(reset_n),
        .cap_pin(cap_pin),
        .cap(cap.ctl)
    );

    // [RULE4] edge code to detector
    assign cap.edge_sel = tacim_edge_e'(st_q.ctrl[CTL_EVT_HI:CTL_EVT_LO]);
    // [RULE6] capture logic live only while enabled
    assign cap.arm = st_q.ctrl[CTL_EN];

    assign wr_ctrl = wr_en && (addr == OFS_CTRL);
    assign wr_mask = wr_en && (addr == OFS_MASK);
    assign wr_clr = wr_en && (addr == OFS_CLR);
    assign rd_raw = rd_en && (addr == OFS_RAW);

    always_comb begin
        events = IRQ_NONE;
        events[IRQ_TA_TO] = ta_timeout;
        events[IRQ_CA_MATCH] = ca_match;
        events[IRQ_CA_EVT] = cap.event_p;
        events[IRQ_RTC] = rtc_match;
        events[IRQ_TB_TO] = tb_timeout;
        events[IRQ_CB_MATCH] = cb_match;
        events[IRQ_CB_EVT] = cb_event;
    end

    // [RULE8] [RULE9] [RULE10] per-bit gating
    // [RULE13] unmasked raw flags drive the line
    assign masked = st_q.raw & st_q.mask;

    always_comb begin
        st_d = st_q;
        clr = IRQ_NONE;
        if (wr_ctrl) begin
            st_d.ctrl = wdata[CTL_W-1:0];
        end
        // [RULE7] mask write, reserved bits held 0
        if (wr_mask) begin
            st_d.mask = wdata[IRQ_W-1:0] & IRQ_WMASK;
        end
        // [RULE12] write-one clear
        if (wr_clr) begin
            clr = wdata[IRQ_W-1:0];
        end
        // reading the raw view also acknowledges it
        if (rd_raw) begin
            clr = IRQ_WMASK;
        end
        // [RULE12] set regardless of mask; set beats clear
        st_d.raw = ((st_q.raw & ~clr) | events) & IRQ_WMASK;
        st_d.rdata = DATA_ZERO;
        if (rd_en) begin
            case (addr)
                OFS_CTRL: st_d.rdata[CTL_W-1:0] = st_q.ctrl;
                OFS_MASK: st_d.rdata[IRQ_W-1:0] = st_q.mask;
                OFS_RAW: st_d.rdata[IRQ_W-1:0] = st_q.raw;
                OFS_MIS: st_d.rdata[IRQ_W-1:0] = masked;
                default: st_d.rdata = DATA_ZERO;
            endcase
        end
        // [RULE1] polarity select
        st_d.pwm = pwm_raw ^ st_q.ctrl[CTL_INV];
        // [RULE2] trigger gate
        st_d.trig = trig_raw & st_q.ctrl[CTL_TRIG];
        // [RULE3] RTC advance gate
        st_d.rtc_adv = rtc_tick & st_q.ctrl[CTL_RTC];
        // [RULE5] [RULE6] enable with debug stall
        st_d.run = st_q.ctrl[CTL_EN]
            & ~(st_q.ctrl[CTL_STALL] & debug_halt);
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            // [RULE11] all mask bits clear at reset
            st_q <= '{ctrl: CTL_RESET, mask: MASK_RESET, raw: IRQ_NONE,
                rdata: DATA_ZERO, default: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata = st_q.rdata;
    assign pwm_out = st_q.pwm;
    assign trig_out = st_q.trig;
    assign rtc_advance = st_q.rtc_adv;
    assign timer_a_run = st_q.run;
    assign irq = |masked;

    // helper: mask stays as it is next cycle
    logic mask_hold;
    assign mask_hold = !wr_mask;

    a_pwm_invert: assert property (@(posedge clock) disable iff (!reset_n) // [RULE1]
        ##1 pwm_out == ($past(pwm_raw) ^ $past(st_q.ctrl[CTL_INV])))
        else $error("pwm output polarity wrong");

    a_trig_gate: assert property (@(posedge clock) disable iff (!reset_n) // [RULE2]
        trig_out |-> $past(trig_raw) && $past(st_q.ctrl[CTL_TRIG]))
        else $error("trigger leaked while disabled");

    a_rtc_halt: assert property (@(posedge clock) disable iff (!reset_n) // [RULE3]
        (rtc_tick && !st_q.ctrl[CTL_RTC]) |=> !rtc_advance)
        else $error("rtc advanced while disabled");

    a_stall_run: assert property (@(posedge clock) disable iff (!reset_n) // [RULE5]
        (st_q.ctrl[CTL_STALL] && debug_halt) |=> !timer_a_run)
        else $error("timer ran during debug stall");

    a_run_enable: assert property (@(posedge clock) disable iff (!reset_n) // [RULE6]
        (st_q.ctrl[CTL_EN] && !debug_halt) |=> timer_a_run)
        else $error("enabled timer not running");

    a_mask_write: assert property (@(posedge clock) disable iff (!reset_n) // [RULE7]
        wr_mask |=> st_q.mask == ($past(wdata[IRQ_W-1:0]) & IRQ_WMASK))
        else $error("mask register did not take write");

    a_tb_timeout: assert property (@(posedge clock) disable iff (!reset_n) // [RULE8]
        (tb_timeout && st_q.mask[IRQ_TB_TO] && mask_hold) |=> irq)
        else $error("timer B timeout not raised");

    a_cae_gate: assert property (@(posedge clock) disable iff (!reset_n) // [RULE9]
        (cap.event_p && st_q.mask[IRQ_CA_EVT] && mask_hold) |=> irq)
        else $error("capture A event not raised");

    a_cam_block: assert property (@(posedge clock) disable iff (!reset_n) // [RULE10]
        (st_q.raw == 11'h002 && !st_q.mask[IRQ_CA_MATCH]) |-> !irq)
        else $error("masked capture A match raised irq");

    a_tato_gate: assert property (@(posedge clock) disable iff (!reset_n) // [RULE11]
        (ta_timeout && st_q.mask[IRQ_TA_TO] && mask_hold) |=> irq)
        else $error("timer A timeout not raised");

    a_raw_set: assert property (@(posedge clock) disable iff (!reset_n) // [RULE12]
        cb_event |=> st_q.raw[IRQ_CB_EVT])
        else $error("raw flag lost its event");

    a_clr_drop: assert property (@(posedge clock) disable iff (!reset_n) // [RULE12]
        (wr_clr && wdata[IRQ_RTC] && !rtc_match) |=> !st_q.raw[IRQ_RTC])
        else $error("clear write did not clear flag");

    a_irq_ack: assert property (@(posedge clock) disable iff (!reset_n) // [RULE13]
        (rd_raw && events == IRQ_NONE) |=> !irq
        && (rdata != DATA_ZERO || !$past(irq)))
        else $error("irq stayed after raw read");

    c_irq_raised: cover property (@(posedge clock) disable iff (!reset_n)
        $rose(irq));
    c_capture_evt: cover property (@(posedge clock) disable iff (!reset_n)
        cap.event_p && st_q.mask[IRQ_CA_EVT]);
    c_set_on_clear: cover property (@(posedge clock) disable iff (!reset_n)
        wr_clr && (wdata[IRQ_W-1:0] & events) != IRQ_NONE);
    c_stalled: cover property (@(posedge clock) disable iff (!reset_n)
        st_q.ctrl[CTL_EN] && st_q.ctrl[CTL_STALL] && debug_halt);
endmodule : tacim_top

// ---- tb/testbench.sv ----
// testbench: self-checking bench for the timer A control and irq mask block.
// assumes the tacim_top register map and one-cycle output latency.
`timescale 1ns/1ps
module testbench;
    import tacim_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    tacim_addr_t addr = '0;
    tacim_data_t wdata = '0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    tacim_data_t rdata;
    logic pwm_raw = 1'b0;
    logic trig_raw = 1'b0;
    logic rtc_tick = 1'b0;
    logic debug_halt = 1'b0;
    logic cap_pin = 1'b0;
    logic [10:0] ev = '0;
    logic pwm_out, trig_out, rtc_advance, timer_a_run, irq;
    logic rd_d1 = 1'b0;
    logic probe = 1'b0;
    tacim_data_t rq[$];
    logic [4:0] oq[$];
    int n_mismatch = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'h0000_0021;
    int pos[6] = '{IRQ_TA_TO, IRQ_CA_MATCH, IRQ_RTC, IRQ_TB_TO,
                   IRQ_CB_MATCH, IRQ_CB_EVT};
    logic [6:0] cc[4] = '{7'h01, 7'h05, 7'h0D, 7'h0C};
    logic [1:0] ce[4] = '{2'h2, 2'h1, 2'h3, 2'h0};

    always #12.5 clock = ~clock;

    tacim_top i_dut (
        .clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .pwm_raw(pwm_raw), .pwm_out(pwm_out),
        .trig_raw(trig_raw), .trig_out(trig_out),
        .rtc_tick(rtc_tick), .rtc_advance(rtc_advance),
        .debug_halt(debug_halt), .timer_a_run(timer_a_run),
        .cap_pin(cap_pin), .ta_timeout(ev[0]), .ca_match(ev[1]),
        .rtc_match(ev[3]), .tb_timeout(ev[8]), .cb_match(ev[9]),
        .cb_event(ev[10]), .irq(irq)
    );

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what,
                     got, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // read data is only meaningful the cycle after the strobe, else zero
    always @(posedge clock) rd_d1 <= rd_en;
    always @(negedge clock) begin
        if (reset_n === 1'b1 && rd_d1 === 1'b1) begin
            chk(rdata, rq.pop_front(), "read data");
        end else if (reset_n === 1'b1) begin
            chk(rdata, DATA_ZERO, "idle read data");
        end
        if (probe === 1'b1) begin
            chk({27'h0, pwm_out, trig_out, rtc_advance, timer_a_run, irq},
                {27'h0, oq.pop_front()}, "outputs");
        end
    end

    // strobes stay up after a transfer; the next step lowers them, so
    // back-to-back calls never assign one strobe twice in a time step
    task automatic wr(input tacim_addr_t a, input tacim_data_t d);
        addr <= a;
        wdata <= d;
        rd_en <= 1'b0;
        wr_en <= 1'b1;
        @(posedge clock);
    endtask : wr

    task automatic rd(input tacim_addr_t a, input tacim_data_t e);
        rq.push_back(e);
        addr <= a;
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge clock);
    endtask : rd

    task automatic look(input logic [4:0] e);
        oq.push_back(e);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        probe <= 1'b1;
        @(posedge clock);
        probe <= 1'b0;
    endtask : look

    task automatic evt(input int p);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        ev <= 11'h001 << p;
        @(posedge clock);
        ev <= '0;
    endtask : evt

    initial begin : watchdog
        repeat (5000) @(posedge clock);
        n_mismatch++;
        $display("ERROR at %0t: run did not finish", $time);
        stop_test();
    end

    initial begin : main
        logic [31:0] r;
        logic [6:0] c;
        logic [31:0] b;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        rd(OFS_MASK, DATA_ZERO);
        rd(OFS_CTRL, DATA_ZERO);
        rd(OFS_RAW, DATA_ZERO);
        wr(12'h100, 32'hFFFF_FFFF);
        rd(12'h100, DATA_ZERO);
        rd(OFS_MASK, DATA_ZERO);
        wr(OFS_MASK, 32'hFFFF_FFFF);
        rd(OFS_MASK, 32'h0000_070F);
        for (int i = 0; i < 8; i++) begin
            r = xs();
            wr(OFS_MASK, r);
            rd(OFS_MASK, r & 32'h0000_070F);
        end
        wr(OFS_MASK, DATA_ZERO);
        for (int i = 0; i < 24; i++) begin
            r = xs();
            c = r[6:0];
            // reserved edge code must never be programmed
            if (c[3:2] == 2'h2) c[3] = 1'b0;
            wr(OFS_CTRL, {25'h0, c});
            rd(OFS_CTRL, {25'h0, c});
            wr_en <= 1'b0;
            rd_en <= 1'b0;
            pwm_raw <= r[8];
            trig_raw <= r[9];
            rtc_tick <= r[10];
            debug_halt <= r[11];
            @(posedge clock);
            look({r[8] ^ c[6], r[9] & c[5], r[10] & c[4],
                  c[0] & ~(c[1] & r[11]), 1'b0});
        end
        pwm_raw <= 1'b0;
        trig_raw <= 1'b0;
        rtc_tick <= 1'b0;
        debug_halt <= 1'b0;
        wr(OFS_CTRL, DATA_ZERO);
        foreach (pos[k]) begin
            b = 32'h0000_0001 << pos[k];
            wr(OFS_MASK, b);
            evt(pos[k]);
            look(5'h01);
            rd(OFS_MIS, b);
            rd(OFS_RAW, b);
            rd(OFS_RAW, DATA_ZERO);
            look(5'h00);
            wr(OFS_MASK, 32'h0000_070F ^ b);
            evt(pos[k]);
            look(5'h00);
            rd(OFS_MIS, DATA_ZERO);
            wr(OFS_MASK, 32'h0000_070F);
            look(5'h01);
            wr(OFS_CLR, b);
            look(5'h00);
        end
        wr(OFS_MASK, 32'h0000_0004);
        for (int k = 0; k < 4; k++) begin
            wr(OFS_CTRL, {25'h0, cc[k]});
            wr_en <= 1'b0;
            cap_pin <= 1'b1;
            // sync, edge detect and flag need four edges; six leave margin
            repeat (6) @(posedge clock);
            look({3'h0, cc[k][0], ce[k][1]});
            rd(OFS_RAW, {29'h0, ce[k][1], 2'h0});
            rd_en <= 1'b0;
            cap_pin <= 1'b0;
            repeat (6) @(posedge clock);
            look({3'h0, cc[k][0], ce[k][0]});
            rd(OFS_RAW, {29'h0, ce[k][0], 2'h0});
        end
        stop_test();
    end
endmodule : testbench
